// *** clock_select.sv ***
// Functional notes
// RL1 - Ten modes, four-bit field caught at power-on
// RL2 - Resistor-cap mode drives quarter clock out
// RL3 - Resistor-cap pin-io mode frees bit 6
// RL4 - Outside clock input, quarter clock out
// RL5 - Outside clock pin-io mode frees bit 6
// RL6 - Outside clock modes need no start-up wait
// RL7 - Onchip mode one: quarter out, bit 7 free
// RL8 - Onchip mode two: bits 6, 7 free
// RL9 - Times-four mode multiplies input by four
// RL10 - Multiplier off in every other mode
// RL11 - 8 MHz source direct or postscaled
// RL12 - 8 MHz source on for 125k to 8M
// RL13 - 31 kHz source on for onchip or features
// RL14 - Frequency pick chooses 8M, 31k or postscaled
// RL15 - Frequency pick sits in bits 6 to 4
// RL16 - Frequency pick write takes effect at once
// RL17 - Code 111 8M, halving down, 000 31k
// RL18 - Clock outputs free of glitches and runts
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`default_nettype none
module clock_select #(
   parameter int unsigned OSC8_DIV  = osc_pkg::OSC8_DIV,
   parameter int unsigned OSC31_DIV = osc_pkg::OSC31_DIV,
   parameter int unsigned OST_EDGES = osc_pkg::OST_EDGES
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output var  logic              hreadyout,
   output var  logic              hresp,
   output var  logic [31:0]       hrdata,
   input  wire logic [3:0]        clk_mode_cfg,
   input  wire logic              clock_in_pin,
   input  wire logic              sleep_req,
   output var  logic              sys_clk_en,
   output var  osc_pkg::pin_ctl_t pins,
   output var  osc_pkg::src_en_t  src_en
);
   typedef struct packed {
      logic              cfg_done;
      logic [3:0]        mode;
      logic              in_prev;
      logic              sleep_prev;
      logic [10:0]       start_cnt;
      logic              primary_ready;
      logic [2:0]        freq_pick;
      logic [3:0]        feat;
      logic [6:0]        post_cnt;
      logic              sys_tick;
      logic [1:0]        div4_cnt;
      osc_pkg::pin_ctl_t pins;
      osc_pkg::src_en_t  src;
      logic              ahb_wr;
      logic              ahb_ok;
      logic [7:0]        ahb_addr;
      logic [31:0]       hrdata;
   } state_t;

   state_t s;
   state_t next_s;
   logic   tick8;
   logic   tick31;
   logic   mult_tick;
   logic   in_rise;
   logic   wake;
   logic   post_hit;
   logic   int_tick;
   logic   prim_tick;
   logic   addr_ok;
   logic   take;

   // Mode class decoders, shared by the logic and its checks; is_outside serves the checks only
   function automatic logic is_internal(input logic [3:0] m);
      return m == osc_pkg::ONCHIP_OSC_DIV4_OUT || m == osc_pkg::ONCHIP_OSC_TWO_PIN_IO;
   endfunction : is_internal

   function automatic logic is_crystal(input logic [3:0] m);
      return m <= osc_pkg::FAST_CRYSTAL_TIMES_FOUR;
   endfunction : is_crystal

   function automatic logic is_outside(input logic [3:0] m);
      return m == osc_pkg::OUTSIDE_CLOCK_DIV4_OUT || m == osc_pkg::OUTSIDE_CLOCK_PIN_IO;
   endfunction : is_outside

   // Postscaler hit mask: code n divides the 8 MHz ticks by 2**(7-n)
   function automatic logic [6:0] post_mask(input logic [2:0] pick);
      return 7'h7f >> pick;
   endfunction : post_mask

   function automatic logic [31:0] read_word(input state_t st, input logic [7:0] a);
      logic [31:0] w;
      w = 32'h0;
      case (a)
         osc_pkg::OSC_CONTROL_REG_OFS: begin
            w[osc_pkg::PICK_LSB +: 3] = st.freq_pick;
            w[osc_pkg::READY_BIT]     = st.primary_ready;
         end
         osc_pkg::FEATURE_EN_OFS: begin
            w[3:0] = st.feat;
         end
         osc_pkg::CLK_STATUS_OFS: begin
            w[3:0] = st.mode;
            w[4]   = st.src.pll_en;
            w[5]   = st.src.osc8_en;
            w[6]   = st.src.osc31_en;
            w[7]   = st.primary_ready;
         end
         default: begin
            w = 32'h0;
         end
      endcase
      return w;
   endfunction : read_word

   // Internal sources are tick dividers off hclk, so their phase is exact only to one cycle
   pulse_divider #(.DIV(OSC8_DIV), .W(11)) osc8_div (
      .hclk    (hclk),
      .hresetn (hresetn),
      .run     (s.src.osc8_en),
      .tick    (tick8)
   );

   pulse_divider #(.DIV(OSC31_DIV), .W(11)) osc31_div (
      .hclk    (hclk),
      .hresetn (hresetn),
      .run     (s.src.osc31_en),
      .tick    (tick31)
   );

   // Multiplier runs only in the times-four mode; elsewhere it sits cleared
   freq_multiplier #(.W(16)) pll (
      .hclk    (hclk),
      .hresetn (hresetn),
      .run     (s.src.pll_en),
      .edge_in (in_rise),
      .tick    (mult_tick)
   );

   // Edge and event detection on the synchronous pins
   assign in_rise   = clock_in_pin & ~s.in_prev;
   assign wake      = s.sleep_prev & ~sleep_req;
   assign post_hit  = tick8 && ((s.post_cnt & post_mask(s.freq_pick)) == post_mask(s.freq_pick)); // [RL17]
   assign int_tick  = (s.freq_pick == osc_pkg::PICK_31KHZ) ? tick31 : post_hit; // [RL14] [RL11]
   assign prim_tick = (s.mode == osc_pkg::FAST_CRYSTAL_TIMES_FOUR) ? mult_tick : in_rise; // [RL9]
   assign addr_ok   = haddr[31:8] == 24'h0;
   assign take      = hsel && hready && htrans[1];

   always_comb begin
      next_s            = s;
      next_s.in_prev    = clock_in_pin;
      next_s.sleep_prev = sleep_req;

      // Strap caught once, on the first edge after reset release
      if (!s.cfg_done) begin
         next_s.cfg_done = 1'b1;
         next_s.mode     = (clk_mode_cfg < osc_pkg::MODE_COUNT) ? clk_mode_cfg
                                                                : osc_pkg::STD_CRYSTAL_RESONATOR; // [RL1]
      end

      // Crystals wait out a start-up count after power-on and wake
      if (!is_crystal(s.mode)) begin
         next_s.primary_ready = s.cfg_done; // [RL6]
      end else if (wake) begin
         next_s.primary_ready = 1'b0;
         next_s.start_cnt     = 11'h0;
      end else if (!s.primary_ready && in_rise) begin
         if (s.start_cnt == 11'(OST_EDGES - 1)) begin
            next_s.primary_ready = 1'b1;
         end else begin
            next_s.start_cnt = s.start_cnt + 11'h1;
         end
      end

      // Source enables
      next_s.src.pll_en   = s.cfg_done && s.mode == osc_pkg::FAST_CRYSTAL_TIMES_FOUR; // [RL10]
      next_s.src.osc8_en  = s.cfg_done && is_internal(s.mode) && s.freq_pick != osc_pkg::PICK_31KHZ; // [RL12]
      next_s.src.osc31_en = s.cfg_done && (is_internal(s.mode) || (|s.feat)); // [RL13]

      // Postscaler advances on each 8 MHz tick
      if (tick8) begin
         next_s.post_cnt = s.post_cnt + 7'h1;
      end

      // System clock is a one-cycle enable; a new pick only reshapes the next tick, never splits one
      next_s.sys_tick = s.cfg_done && !sleep_req &&
                        (is_internal(s.mode) ? int_tick : (s.primary_ready && prim_tick)); // [RL16] [RL18]

      // Quarter-rate output toggles on every second tick, so it has no runt phase
      if (s.sys_tick) begin
         next_s.div4_cnt = s.div4_cnt + 2'h1; // [RL18]
      end

      // Pin hand-over per mode
      next_s.pins = '0;
      case (s.mode)
         osc_pkg::RESISTOR_CAP_OSC_DIV4_OUT, osc_pkg::OUTSIDE_CLOCK_DIV4_OUT: begin
            next_s.pins.clk_out_oe = s.cfg_done; // [RL2] [RL4]
            next_s.pins.clk_out_o  = s.div4_cnt[1];
         end
         osc_pkg::RESISTOR_CAP_OSC_PIN_IO, osc_pkg::OUTSIDE_CLOCK_PIN_IO: begin
            next_s.pins.bit6_gpio = s.cfg_done; // [RL3] [RL5]
         end
         osc_pkg::ONCHIP_OSC_DIV4_OUT: begin
            next_s.pins.clk_out_oe = s.cfg_done; // [RL7]
            next_s.pins.clk_out_o  = s.div4_cnt[1];
            next_s.pins.bit7_gpio  = s.cfg_done;
         end
         osc_pkg::ONCHIP_OSC_TWO_PIN_IO: begin
            next_s.pins.bit6_gpio = s.cfg_done; // [RL8]
            next_s.pins.bit7_gpio = s.cfg_done;
         end
         default: begin
            next_s.pins = '0;
         end
      endcase

      // Bus data phase of a write
      if (s.ahb_wr && s.ahb_ok) begin
         case (s.ahb_addr)
            osc_pkg::OSC_CONTROL_REG_OFS: begin
               next_s.freq_pick = hwdata[osc_pkg::PICK_LSB +: 3]; // [RL15] [RL16]
            end
            osc_pkg::FEATURE_EN_OFS: begin
               next_s.feat = hwdata[3:0];
            end
            default: begin
               next_s.feat = next_s.feat;
            end
         endcase
      end

      // Bus address phase; read data sees a write that finishes in the same cycle
      next_s.ahb_wr   = take && hwrite;
      next_s.ahb_ok   = addr_ok;
      next_s.ahb_addr = haddr[7:0];
      if (take && !hwrite) begin
         next_s.hrdata = addr_ok ? read_word(next_s, haddr[7:0]) : 32'h0;
      end
   end

   // Reset holds a crystal mode until the strap is caught, so no pin is handed over early
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s           <= '0;
         s.mode      <= osc_pkg::STD_CRYSTAL_RESONATOR;
         s.freq_pick <= osc_pkg::PICK_RST;
         s.feat      <= osc_pkg::FEAT_RST;
      end else begin
         s <= next_s;
      end
   end

   // Zero-wait slave, always OKAY; hsize is not checked, only words are supported
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign hrdata     = s.hrdata;
   assign sys_clk_en = s.sys_tick;
   assign pins       = s.pins;
   assign src_en     = s.src;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // Strap and pin hand-over
   mode_hold_a: assert property (s.cfg_done |=> $stable(s.mode)) // [RL1]
      else $error("mode changed after power-on");
   rc_out_a: assert property (s.cfg_done && s.mode == osc_pkg::RESISTOR_CAP_OSC_DIV4_OUT // [RL2]
      |=> pins.clk_out_oe && pins.clk_out_o == $past(s.div4_cnt[1]))
      else $error("resistor-cap quarter clock missing");
   resistor_cap_osc_pin_io_gpio_a: assert property (s.cfg_done && s.mode == osc_pkg::RESISTOR_CAP_OSC_PIN_IO // [RL3]
      |=> pins.bit6_gpio && !pins.clk_out_oe)
      else $error("resistor-cap pin not released");
   ec_out_a: assert property (s.cfg_done && s.mode == osc_pkg::OUTSIDE_CLOCK_DIV4_OUT // [RL4]
      |=> pins.clk_out_oe && pins.clk_out_o == $past(s.div4_cnt[1]))
      else $error("outside clock quarter output missing");
   outside_clock_pin_io_gpio_a: assert property (s.cfg_done && s.mode == osc_pkg::OUTSIDE_CLOCK_PIN_IO // [RL5]
      |=> pins.bit6_gpio && !pins.clk_out_oe)
      else $error("outside clock pin not released");
   crystal_pins_a: assert property (s.cfg_done && is_crystal(s.mode) |=> pins == '0) // [RL1]
      else $error("crystal mode handed a pin over");

   // Outside clocks run at once, after power-on and after wake alike; onchip mode pin hand-over
   ext_nowait_a: assert property (s.cfg_done && is_outside(s.mode) |=> s.primary_ready) // [RL6]
      else $error("outside clock waited for start-up");
   ext_wake_a: assert property (s.cfg_done && is_outside(s.mode) && wake |=> s.primary_ready) // [RL6]
      else $error("outside clock waited after wake");
   int1_pins_a: assert property (s.cfg_done && s.mode == osc_pkg::ONCHIP_OSC_DIV4_OUT // [RL7]
      |=> pins.clk_out_oe && pins.bit7_gpio && !pins.bit6_gpio)
      else $error("onchip mode one pins wrong");
   int2_pins_a: assert property (s.cfg_done && s.mode == osc_pkg::ONCHIP_OSC_TWO_PIN_IO // [RL8]
      |=> pins.bit6_gpio && pins.bit7_gpio && !pins.clk_out_oe)
      else $error("onchip mode two pins wrong");

   // Source enables follow the mode and the frequency pick
   pll_only_a: assert property (src_en.pll_en |-> s.mode == osc_pkg::FAST_CRYSTAL_TIMES_FOUR) // [RL10]
      else $error("multiplier on outside its mode");
   direct_8m_a: assert property (s.cfg_done && is_internal(s.mode) && s.freq_pick == osc_pkg::PICK_8MHZ // [RL11]
      && tick8 && !sleep_req |=> sys_clk_en)
      else $error("8 MHz tick not passed directly");
   osc8_en_a: assert property (s.cfg_done |=> src_en.osc8_en == // [RL12]
      $past(is_internal(s.mode) && s.freq_pick != osc_pkg::PICK_31KHZ))
      else $error("8 MHz enable wrong");
   osc31_en_a: assert property (s.cfg_done |=> src_en.osc31_en == $past(is_internal(s.mode) || (|s.feat))) // [RL13]
      else $error("31 kHz enable wrong");

   // Bus writes and output shaping
   pick_write_a: assert property (s.ahb_wr && s.ahb_ok && s.ahb_addr == osc_pkg::OSC_CONTROL_REG_OFS // [RL16]
      |=> s.freq_pick == $past(hwdata[6:4]))
      else $error("frequency pick not taken");
   out_steady_a: assert property ($changed(s.div4_cnt) |-> $past(s.sys_tick)) // [RL18]
      else $error("quarter output moved without a tick");

   // Every system tick traces back to a tick of the chosen source; a stray one would be a runt
   post_src_a: assert property (s.cfg_done && is_internal(s.mode) && s.freq_pick != osc_pkg::PICK_31KHZ // [RL11]
      && !tick8 |=> !sys_clk_en)
      else $error("onchip tick without an 8 MHz tick");
   slow_src_a: assert property (s.cfg_done && is_internal(s.mode) && s.freq_pick == osc_pkg::PICK_31KHZ // [RL14]
      && !tick31 |=> !sys_clk_en)
      else $error("slow pick tick without a 31 kHz tick");
   pll_src_a: assert property (s.mode == osc_pkg::FAST_CRYSTAL_TIMES_FOUR && !mult_tick |=> !sys_clk_en) // [RL9]
      else $error("times-four tick without a multiplier tick");
   pin_src_a: assert property (!is_internal(s.mode) && s.mode != osc_pkg::FAST_CRYSTAL_TIMES_FOUR // [RL4]
      && !in_rise |=> !sys_clk_en)
      else $error("outside tick without an input edge");

   // Main scenarios
   pll_run_c: cover property (src_en.pll_en && sys_clk_en);
   pick_change_c: cover property (is_internal(s.mode) && $changed(s.freq_pick) ##[1:300] sys_clk_en);
   crystal_wake_c: cover property (is_crystal(s.mode) && wake ##[1:1000] $rose(s.primary_ready));
   slow_pick_c: cover property (is_internal(s.mode) && s.freq_pick == osc_pkg::PICK_31KHZ && sys_clk_en);
   quarter_out_c: cover property (is_outside(s.mode) && $rose(pins.clk_out_o));
endmodule : clock_select
`default_nettype wire

// *** osc_pkg.sv ***
`default_nettype none
package osc_pkg;
   // Rates and derived cycle counts
   localparam int unsigned CLK_HZ    = 40_000_000;
   localparam int unsigned OSC8_HZ   = 8_000_000;
   localparam int unsigned OSC31_HZ  = 31_250;
   localparam int unsigned OSC8_DIV  = CLK_HZ / OSC8_HZ;
   localparam int unsigned OSC31_DIV = CLK_HZ / OSC31_HZ;
   localparam int unsigned OST_EDGES = 1024;
   localparam int unsigned PLL_MULT  = 4;

   // Oscillator mode codes of the non-volatile field
   localparam logic [3:0] LOW_POWER_CRYSTAL         = 4'h0;
   localparam logic [3:0] STD_CRYSTAL_RESONATOR     = 4'h1;
   localparam logic [3:0] FAST_CRYSTAL_RESONATOR    = 4'h2;
   localparam logic [3:0] FAST_CRYSTAL_TIMES_FOUR   = 4'h3;
   localparam logic [3:0] RESISTOR_CAP_OSC_DIV4_OUT = 4'h4;
   localparam logic [3:0] RESISTOR_CAP_OSC_PIN_IO   = 4'h5;
   localparam logic [3:0] ONCHIP_OSC_DIV4_OUT       = 4'h6;
   localparam logic [3:0] ONCHIP_OSC_TWO_PIN_IO     = 4'h7;
   localparam logic [3:0] OUTSIDE_CLOCK_DIV4_OUT    = 4'h8;
   localparam logic [3:0] OUTSIDE_CLOCK_PIN_IO      = 4'h9;
   localparam logic [3:0] MODE_COUNT                = 4'ha;

   // Register byte offsets
   localparam logic [7:0] OSC_CONTROL_REG_OFS = 8'h00;
   localparam logic [7:0] FEATURE_EN_OFS      = 8'h04;
   localparam logic [7:0] CLK_STATUS_OFS      = 8'h08;

   // Field positions and reset values
   localparam int unsigned PICK_LSB   = 4;
   localparam int unsigned READY_BIT  = 3;
   localparam logic [2:0]  PICK_RST   = 3'h0;
   localparam logic [2:0]  PICK_31KHZ = 3'h0;
   localparam logic [2:0]  PICK_8MHZ  = 3'h7;
   localparam logic [3:0]  FEAT_RST   = 4'h0;

   // Pin hand-over to the port logic
   typedef struct packed {
      logic clk_out_o;
      logic clk_out_oe;
      logic bit6_gpio;
      logic bit7_gpio;
   } pin_ctl_t;

   // Source enables
   typedef struct packed {
      logic pll_en;
      logic osc8_en;
      logic osc31_en;
   } src_en_t;
endpackage : osc_pkg
`default_nettype wire

// *** pulse_divider.sv ***
`default_nettype none
module pulse_divider #(
   parameter int unsigned DIV = 5,
   parameter int unsigned W   = 11
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic run,
   output var  logic tick
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } div_state_t;

   div_state_t s;
   div_state_t next_s;

   // Counter stops and clears while the source is disabled
   always_comb begin
      next_s      = s;
      next_s.tick = 1'b0;
      if (!run) begin
         next_s.cnt = '0;
      end else if (s.cnt == W'(DIV - 1)) begin
         next_s.cnt  = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt = s.cnt + W'(1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;
endmodule : pulse_divider
`default_nettype wire

// *** freq_multiplier.sv ***
`default_nettype none
module freq_multiplier #(
   parameter int unsigned W = 16
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic run,
   input  wire logic edge_in,
   output var  logic tick
);
   typedef struct packed {
      logic [W-1:0] period;
      logic [W-1:0] quarter;
      logic [W-1:0] phase;
      logic [1:0]   slot;
      logic         tick;
   } mult_state_t;

   mult_state_t s;
   mult_state_t next_s;

   // Measure the input period, then emit evenly spaced ticks within it
   always_comb begin
      next_s      = s;
      next_s.tick = 1'b0;
      if (!run) begin
         next_s = '0;
      end else if (edge_in) begin
         next_s.quarter = (s.period + W'(1)) >> 2;
         next_s.period  = '0;
         next_s.phase   = '0;
         next_s.slot    = '0;
         next_s.tick    = 1'b1;
      end else begin
         if (s.period != '1) begin
            next_s.period = s.period + W'(1);
         end
         // Extra ticks stop after the third, four ticks in all with the edge tick; a slow input never overruns
         if (s.quarter != '0 && s.slot != 2'(osc_pkg::PLL_MULT - 1)) begin
            if (s.phase + W'(1) == s.quarter) begin
               next_s.phase = '0;
               next_s.slot  = s.slot + 2'h1;
               next_s.tick  = 1'b1;
            end else begin
               next_s.phase = s.phase + W'(1);
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;
endmodule : freq_multiplier
`default_nettype wire

// *** ext_clock_src.sv ***
`default_nettype none
// Outside clock generator on the first oscillator pin, synchronous to hclk
module ext_clock_src (
   input  wire logic       hclk,
   input  wire logic       run,
   input  wire logic [7:0] half,
   output var  logic       pin_level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt;

   // Toggle every half cycles; a stopped source rests low so no stale edge is seen
   always_ff @(posedge hclk) begin
      if (!run) begin
         cnt       <= 8'h00;
         pin_level <= 1'b0;
      end else if (cnt + 8'h01 >= half) begin
         cnt       <= 8'h00;
         pin_level <= ~pin_level;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule : ext_clock_src
`default_nettype wire

// *** oscillator_mode_clock_select_tb.sv ***
`default_nettype none
module oscillator_mode_clock_select_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int O31 = 8;
   localparam int OST = 4;
   logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp, sleep_req, clock_in_pin, sys_clk_en, co_prev;
   logic [31:0]       haddr, hwdata, hrdata, rdat;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic [3:0]        cfg;
   logic [7:0]        half;
   osc_pkg::pin_ctl_t pins;
   osc_pkg::src_en_t  src_en;
   int                failures, n_compared, cyc, last_tk, tk_ival, ntk, last_co, co_ival;

   clock_select #(.OSC31_DIV(O31), .OST_EDGES(OST)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .clk_mode_cfg(cfg), .clock_in_pin(clock_in_pin), .sleep_req(sleep_req),
      .sys_clk_en(sys_clk_en), .pins(pins), .src_en(src_en));
   ext_clock_src i_src (.hclk(hclk), .run(hresetn), .half(half), .pin_level(clock_in_pin));

   // 40 MHz clock
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   // Cycle count, plus tick and quarter-clock intervals sampled away from the launching edge
   always @(posedge hclk) cyc <= cyc + 1;
   always @(negedge hclk) begin
      if (sys_clk_en === 1'b1) begin
         tk_ival = cyc - last_tk;
         last_tk = cyc;
         ntk++;
      end
      if (pins.clk_out_o === 1'b1 && co_prev !== 1'b1) begin
         co_ival = cyc - last_co;
         last_co = cyc;
      end
      co_prev = pins.clk_out_o;
   end

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check_val

   task automatic check_cnt(input int got, input int lo, input int hi, input string what);
      n_compared++;
      if (got < lo || got > hi) begin
         failures++;
         $display("ERROR t=%0t %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
      end
   endtask : check_cnt

   // One single transfer; hreadyout is the bus ready, so waits end only on ready
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   // Reset with a strap value; the mode is only caught after release
   task automatic start(input logic [3:0] m);
      hresetn <= 1'b0;
      cfg     <= m;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      ntk = 0;
      co_ival = 0;
   endtask : start

   task automatic t_modes();
      logic [3:0] e;
      for (int m = 0; m < 16; m++) begin
         start(4'(m));
         repeat (4) @(posedge hclk);
         e = (m < 10) ? 4'(m) : 4'h1;
         @(negedge hclk);
         check_val(32'({pins.clk_out_oe, pins.bit6_gpio, pins.bit7_gpio}), 32'({e inside {4'h4, 4'h6, 4'h8},
            e inside {4'h5, 4'h7, 4'h9}, e inside {4'h6, 4'h7}}), "pin hand-over");
         check_val(32'(src_en), 32'({e == 4'h3, 1'b0, e inside {4'h6, 4'h7}}), "source enables");
         @(posedge hclk);
         bus(1'b0, 32'h8, 32'h0, rdat);
         check_val(32'(rdat[6:0]), 32'({e inside {4'h6, 4'h7}, 1'b0, e == 4'h3, e}), "mode status");
      end
      $display("test modes done");
   endtask : t_modes

   // Start-up wait, tick rate, quarter clock and wake from sleep
   task automatic t_start(input logic [3:0] m, input bit slow);
      int qc;
      half <= 8'h04;
      start(m);
      qc = (slow || m == osc_pkg::OUTSIDE_CLOCK_PIN_IO) ? 0 : 32;
      repeat (20) @(posedge hclk);
      check_cnt(ntk, 0, slow ? 0 : 3, "ticks after reset");
      if (!slow) check_cnt(ntk, 1, 3, "early ticks");
      repeat (80) @(posedge hclk);
      @(negedge hclk);
      check_cnt(tk_ival, 8, 8, "tick spacing");
      check_cnt(co_ival, qc, qc, "quarter clock period");
      @(posedge hclk);
      sleep_req <= 1'b1;
      repeat (4) @(posedge hclk);
      ntk = 0;
      repeat (40) @(posedge hclk);
      check_cnt(ntk, 0, 0, "ticks in sleep");
      sleep_req <= 1'b0;
      ntk = 0;
      repeat (20) @(posedge hclk);
      check_cnt(ntk, slow ? 0 : 1, slow ? 0 : 3, "ticks after wake");
      $display("test start mode %0d done", m);
   endtask : t_start

   task automatic t_pll();
      half <= 8'h08;
      start(osc_pkg::FAST_CRYSTAL_TIMES_FOUR);
      repeat (160) @(posedge hclk);
      ntk = 0;
      repeat (64) @(posedge hclk);
      @(negedge hclk);
      check_cnt(ntk, 15, 17, "multiplied ticks");
      check_cnt(tk_ival, 4, 4, "multiplied spacing");
      @(posedge hclk);
      $display("test pll done");
   endtask : t_pll

   task automatic t_onchip();
      int e;
      start(osc_pkg::ONCHIP_OSC_DIV4_OUT);
      @(posedge hclk);
      for (int k = 7; k >= 0; k--) begin
         bus(1'b1, 32'h0, 32'(k) << 4, rdat);
         bus(1'b0, 32'h0, 32'h0, rdat);
         check_val(32'(rdat[6:4]), 32'(k), "pick readback");
         e = (k == 0) ? O31 : (5 << (7 - k));
         repeat (((k == 7) ? 8 : 2) * e + 10) @(posedge hclk);
         @(negedge hclk);
         check_cnt(tk_ival, e, e, "onchip tick spacing");
         check_val(32'({src_en.osc8_en, src_en.osc31_en}), 32'({k != 0, 1'b1}), "onchip sources");
         if (k == 7) check_cnt(co_ival, 4 * e, 4 * e, "onchip quarter clock");
         @(posedge hclk);
      end
      $display("test onchip done");
   endtask : t_onchip

   task automatic t_regs();
      start(osc_pkg::OUTSIDE_CLOCK_DIV4_OUT);
      repeat (4) @(posedge hclk);
      bus(1'b0, 32'h0, 32'h0, rdat);
      check_val(rdat, 32'h0000_0008, "control reset value");
      for (int b = 0; b < 4; b++) begin
         bus(1'b1, 32'h4, 32'h1 << b, rdat);
         bus(1'b0, 32'h4, 32'h0, rdat);
         check_val(rdat, 32'h1 << b, "feature readback");
         repeat (2) @(posedge hclk);
         @(negedge hclk);
         check_val(32'(src_en.osc31_en), 32'h1, "slow source for feature");
         @(posedge hclk);
         bus(1'b1, 32'h4, 32'h0, rdat);
         repeat (2) @(posedge hclk);
         @(negedge hclk);
         check_val(32'(src_en.osc31_en), 32'h0, "slow source idle");
         @(posedge hclk);
      end
      bus(1'b1, 32'hc, 32'hffff_ffff, rdat);
      bus(1'b1, 32'h104, 32'hf, rdat);
      bus(1'b1, 32'h8, 32'h0, rdat);
      bus(1'b0, 32'hc, 32'h0, rdat);
      check_val(rdat, 32'h0, "unmapped read");
      bus(1'b0, 32'h4, 32'h0, rdat);
      check_val(rdat, 32'h0, "high address write ignored");
      bus(1'b0, 32'h8, 32'h0, rdat);
      check_val(32'(rdat[3:0]), 32'h8, "status not writable");
      $display("test regs done");
   endtask : t_regs

   task automatic results();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results

   // Whole run is a few thousand cycles; this bound only catches a hang
   initial begin
      repeat (30000) @(posedge hclk);
      failures++;
      $display("ERROR t=%0t watchdog expired", $time);
      results();
   end

   initial begin
      hresetn   = 1'b0;
      hsel      = 1'b0;
      haddr     = 32'h0;
      htrans    = 2'h0;
      hwrite    = 1'b0;
      hsize     = 3'h2;
      hwdata    = 32'h0;
      cfg       = 4'h0;
      sleep_req = 1'b0;
      half      = 8'h04;
      @(posedge hclk);
      t_modes();
      t_start(osc_pkg::OUTSIDE_CLOCK_DIV4_OUT, 1'b0);
      t_start(osc_pkg::RESISTOR_CAP_OSC_DIV4_OUT, 1'b0);
      t_start(osc_pkg::OUTSIDE_CLOCK_PIN_IO, 1'b0);
      t_start(osc_pkg::FAST_CRYSTAL_RESONATOR, 1'b1);
      t_pll();
      t_onchip();
      t_regs();
      results();
   end
endmodule : oscillator_mode_clock_select_tb
`default_nettype wire
